/* bench/test_synth_ref_path_config_regs.sv */
`timescale 1ns/1ps
module test_synth_ref_path_config_regs;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic ce_in = 1'b1;
   logic csb_n = 1'b1;
   logic sck = 1'b0;
   logic sdi = 1'b0;
   logic sdo, sdo_oe, dbl, pump, single;
   logic [4:0] input_path_multiplier;
   logic [7:0] post;
   logic [11:0] pre;
   logic [1:0] mode;
   logic [15:0] mirror [0:5];
   logic [31:0] rd_seen;
   logic [31:0] fields_seen;
   // Comparison frequency the bench claims to run the detector at, in MHz
   int pfd_mhz = 250;
   logic [31:0] exp_q [$];
   int errors = 0;
   int tests_run = 0;
   int seed = 32'h38CC;
   event seen_f, seen_r;

   srp_ref_path_regs dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .spi_csb_n_in(csb_n),
      .spi_sck_in(sck), .spi_sdi_in(sdi), .spi_sdo_out(sdo), .spi_sdo_oe_out(sdo_oe),
      .ref_doubler_enable_out(dbl), .input_path_multiplier_out(input_path_multiplier), .post_input_path_multiplier_divider_out(post),
      .pre_input_path_multiplier_divider_out(pre), .pump_enable_out(pump), .detector_mode_sel_out(mode),
      .single_detector_out(single));

   always #10 clk_in = ~clk_in;

   task check(input logic [31:0] got, input logic [31:0] want);
      tests_run++;
      if (got !== want) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, want);
      end
   endtask

   task results;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Serial output must be quiet and released between frames
   assign fields_seen = {sdo, sdo_oe, dbl, input_path_multiplier, post, pre, pump, mode, single};
   always @(seen_f) check(fields_seen, exp_q.pop_front());
   always @(seen_r) check(rd_seen, exp_q.pop_front());

   function automatic logic [31:0] model();
      return {2'h0, mirror[0][11], mirror[1][11:7], mirror[2][11:4], mirror[3][11:0], mirror[4][14],
              mirror[4][1:0], mirror[4][1:0] == 2'h3};
   endfunction

   // Sck half period of 8 clocks keeps each pin level past the input filter
   // Result is published only at the end so the checker never sees a half-built word
   task frame(input logic rw, input logic [6:0] a, input logic [15:0] d, input int cut);
      logic [23:0] w;
      logic [15:0] got;
      logic oe_all;
      w = {rw, a, d};
      got = 16'h0000;
      oe_all = 1'b1;
      csb_n = 1'b0;
      repeat (8) @(negedge clk_in);
      for (int i = 23; i >= cut; i--) begin
         sck = 1'b0;
         sdi = w[i];
         repeat (8) @(negedge clk_in);
         if (i < 16) begin
            got[i] = sdo;
            oe_all = oe_all & sdo_oe;
         end
         sck = 1'b1;
         repeat (8) @(negedge clk_in);
      end
      sck = 1'b0;
      repeat (8) @(negedge clk_in);
      csb_n = 1'b1;
      repeat (10) @(negedge clk_in);
      rd_seen = {15'h0000, oe_all, got};
   endtask

   task note_fields;
      exp_q.push_back(model());
      ->seen_f;
   endtask

   task wr(input logic [6:0] a, input logic [15:0] d);
      frame(1'b0, a, d, 0);
      if (a >= 7'h09 && a <= 7'h0E) mirror[a - 7'h09] = d;
      note_fields();
   endtask

   task rd(input logic [6:0] a);
      frame(1'b1, a, 16'h0000, 0);
      exp_q.push_back({15'h0000, 1'b1, (a >= 7'h09 && a <= 7'h0E) ? mirror[a - 7'h09] : 16'h0000});
      ->seen_r;
   endtask

   task reset_mirror;
      mirror = '{16'h0000, 16'h0000, 16'h0010, 16'h0001, 16'h4000, 16'h0000};
   endtask

   // Named field bits only, plus bits 11:0 of the unnamed 0x0E word; everything else keeps its default
   logic [15:0] masks [0:5] = '{16'h0800, 16'h0F80, 16'h0FF0, 16'h0FFF, 16'h4003, 16'h0FFF};

   initial begin
      reset_mirror();
      repeat (20) @(negedge clk_in);
      rst_n_in = 1'b1;
      repeat (6) @(negedge clk_in);
      note_fields();
      for (int a = 9; a <= 14; a++) rd(7'(a));
      for (int r = 0; r < 2; r++) begin
         for (int a = 9; a <= 14; a++) begin
            wr(7'(a), (mirror[a - 9] & ~masks[a - 9]) | (16'($random(seed)) & masks[a - 9]));
            rd(7'(a));
         end
      end
      for (int m = 0; m < 4; m++) if (m != 3 || pfd_mhz > 200) wr(7'h0D, 16'h4000 | 16'(m));
      wr(7'h0D, 16'h0000);
      wr(7'h0D, 16'h4000);
      wr(7'h0B, 16'h0FF0);
      wr(7'h0C, 16'h0FFF);
      wr(7'h0A, 16'h0F80);
      wr(7'h09, 16'h0800);
      wr(7'h0F, 16'h0FFF);
      rd(7'h0F);
      rd(7'h08);
      // Frame cut after 16 bits must leave the divider alone
      frame(1'b0, 7'h0B, 16'h0AB0, 8);
      note_fields();
      rst_n_in = 1'b0;
      repeat (3) @(negedge clk_in);
      rst_n_in = 1'b1;
      reset_mirror();
      repeat (6) @(negedge clk_in);
      note_fields();
      rd(7'h0D);
      results();
   end

   initial begin
      repeat (40000) @(posedge clk_in);
      errors++;
      results();
   end
endmodule

/* common/srp_pkg.sv */
package srp_pkg;
   localparam int unsigned SRP_ADDR_W = 7;
   localparam int unsigned SRP_DATA_W = 16;
   localparam logic [4:0] SRP_LAST_BIT = 5'h17;
   localparam logic [4:0] SRP_ADDR_DONE_BIT = 5'h07;
   localparam int unsigned SRP_NUM_REGS = 6;

   localparam logic [6:0] SRP_OFS_DOUBLER = 7'h09;
   localparam logic [6:0] SRP_OFS_INPUT_PATH_MULTIPLIER = 7'h0A;
   localparam logic [6:0] SRP_OFS_POST_DIV = 7'h0B;
   localparam logic [6:0] SRP_OFS_PRE_DIV = 7'h0C;
   localparam logic [6:0] SRP_OFS_PUMP_DET = 7'h0D;
   localparam logic [6:0] SRP_OFS_PUMP_CUR = 7'h0E;
   localparam logic [6:0] SRP_OFS_BASE = SRP_OFS_DOUBLER;

   localparam int unsigned SRP_DOUBLER_BIT = 11;
   localparam int unsigned SRP_INPUT_PATH_MULTIPLIER_LSB = 7;
   localparam int unsigned SRP_INPUT_PATH_MULTIPLIER_MSB = 11;
   localparam int unsigned SRP_POST_LSB = 4;
   localparam int unsigned SRP_POST_MSB = 11;
   localparam int unsigned SRP_PRE_LSB = 0;
   localparam int unsigned SRP_PRE_MSB = 11;
   localparam int unsigned SRP_PUMP_BIT = 14;
   localparam int unsigned SRP_MODE_LSB = 0;
   localparam int unsigned SRP_MODE_MSB = 1;

   localparam logic [1:0] SRP_MODE_DUAL = 2'h0;
   localparam logic [1:0] SRP_MODE_SINGLE = 2'h3;

   // Unnamed bits reset to zero; software restores the map defaults
   localparam logic [15:0] SRP_RST_DOUBLER = 16'h0000;
   localparam logic [15:0] SRP_RST_INPUT_PATH_MULTIPLIER = 16'h0000;
   localparam logic [15:0] SRP_RST_POST_DIV = 16'h0010;
   localparam logic [15:0] SRP_RST_PRE_DIV = 16'h0001;
   localparam logic [15:0] SRP_RST_PUMP_DET = 16'h4000;
   localparam logic [15:0] SRP_RST_PUMP_CUR = 16'h0000;

   // Pin vector order: csb, sck, sdi
   localparam logic [2:0] SRP_PIN_RST = 3'h1;

   typedef enum logic [2:0] {
      SRP_IDLE = 3'b001,
      SRP_SHIFT = 3'b010,
      SRP_DONE = 3'b100
   } srp_state_e;
endpackage

/* hdl/srp_ref_path_regs.sv */
`timescale 1ns/1ps
module srp_ref_path_regs (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic spi_csb_n_in,
   input wire logic spi_sck_in,
   input wire logic spi_sdi_in,
   output logic spi_sdo_out,
   output logic spi_sdo_oe_out,
   output logic ref_doubler_enable_out,
   output logic [4:0] input_path_multiplier_out,
   output logic [7:0] post_input_path_multiplier_divider_out,
   output logic [11:0] pre_input_path_multiplier_divider_out,
   output logic pump_enable_out,
   output logic [1:0] detector_mode_sel_out,
   output logic single_detector_out
);
   localparam logic [15:0] RST_WORDS [srp_pkg::SRP_NUM_REGS] = '{
      srp_pkg::SRP_RST_DOUBLER, srp_pkg::SRP_RST_INPUT_PATH_MULTIPLIER, srp_pkg::SRP_RST_POST_DIV,
      srp_pkg::SRP_RST_PRE_DIV, srp_pkg::SRP_RST_PUMP_DET, srp_pkg::SRP_RST_PUMP_CUR};

   function automatic logic addr_hit(input logic [6:0] addr);
      addr_hit = (addr >= srp_pkg::SRP_OFS_DOUBLER) && (addr <= srp_pkg::SRP_OFS_PUMP_CUR);
   endfunction

   function automatic logic [2:0] addr_idx(input logic [6:0] addr);
      logic [6:0] diff;
      diff = addr - srp_pkg::SRP_OFS_BASE;
      addr_idx = diff[2:0];
   endfunction

   logic [2:0] pin_s1_q;
   logic [2:0] pin_s2_q;
   logic [2:0] pin_s3_q;
   logic [2:0] pin_f_q;
   logic [2:0] pin_f_d;
   logic [2:0] pin_agree;
   srp_pkg::srp_state_e state_q;
   srp_pkg::srp_state_e state_d;
   logic [4:0] bit_cnt_q;
   logic [23:0] shift_q;
   logic [15:0] rd_shift_q;
   logic rd_act_q;
   logic sdo_q;
   logic single_q;
   logic [15:0] regs_q [srp_pkg::SRP_NUM_REGS];

   // A change counts once the second and third stages agree
   assign pin_agree = ~(pin_s2_q ^ pin_s3_q);
   assign pin_f_d = (pin_s2_q & pin_agree) | (pin_f_q & ~pin_agree);

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pin_s1_q <= srp_pkg::SRP_PIN_RST;
         pin_s2_q <= srp_pkg::SRP_PIN_RST;
         pin_s3_q <= srp_pkg::SRP_PIN_RST;
         pin_f_q <= srp_pkg::SRP_PIN_RST;
      end else if (ce_in) begin
         pin_s1_q <= {spi_sdi_in, spi_sck_in, spi_csb_n_in};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         pin_f_q <= pin_f_d;
      end
   end

   logic cs_act;
   logic sck_rise;
   logic sck_fall;
   logic sdi_bit;
   logic last_rise;
   logic addr_rise;
   logic wr_stb;
   logic [6:0] wr_addr;
   logic [15:0] wr_data;
   logic [6:0] rd_addr;
   logic rd_req;
   logic [15:0] rd_word;

   assign cs_act = ~pin_f_d[0] & ~pin_f_q[0];
   assign sck_rise = ce_in & cs_act & pin_f_d[1] & ~pin_f_q[1];
   assign sck_fall = ce_in & cs_act & ~pin_f_d[1] & pin_f_q[1];
   assign sdi_bit = pin_f_d[2];
   assign last_rise = sck_rise && (state_q == srp_pkg::SRP_SHIFT) && (bit_cnt_q == srp_pkg::SRP_LAST_BIT);
   assign addr_rise = sck_rise && (state_q == srp_pkg::SRP_SHIFT) && (bit_cnt_q == srp_pkg::SRP_ADDR_DONE_BIT);
   // Frame is R/W bit (1 = read), 7 address bits, 16 data bits, MSB first
   assign wr_addr = shift_q[21:15];
   assign wr_data = {shift_q[14:0], sdi_bit};
   assign wr_stb = last_rise & ~shift_q[22] & addr_hit(wr_addr);
   assign rd_addr = {shift_q[5:0], sdi_bit};
   assign rd_req = shift_q[6];
   // Unmapped addresses read as zero and ignore writes
   assign rd_word = addr_hit(rd_addr) ? regs_q[addr_idx(rd_addr)] : 16'h0000;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         srp_pkg::SRP_IDLE: begin
            if (cs_act) begin
               state_d = srp_pkg::SRP_SHIFT;
            end
         end
         srp_pkg::SRP_SHIFT: begin
            if (!cs_act) begin
               state_d = srp_pkg::SRP_IDLE;
            end else if (last_rise) begin
               state_d = srp_pkg::SRP_DONE;
            end
         end
         srp_pkg::SRP_DONE: begin
            // Extra clocks after a full frame are ignored until chip select lifts
            if (!cs_act) begin
               state_d = srp_pkg::SRP_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_q <= srp_pkg::SRP_IDLE;
         bit_cnt_q <= 5'h00;
         shift_q <= 24'h000000;
      end else if (ce_in) begin
         state_q <= state_d;
         if (state_q != srp_pkg::SRP_SHIFT) begin
            bit_cnt_q <= 5'h00;
         end else if (sck_rise) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
            shift_q <= {shift_q[22:0], sdi_bit};
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rd_act_q <= 1'b0;
         rd_shift_q <= 16'h0000;
         sdo_q <= 1'b0;
      end else if (ce_in) begin
         if (!cs_act) begin
            rd_act_q <= 1'b0;
            sdo_q <= 1'b0;
         end else if (addr_rise) begin
            rd_act_q <= rd_req;
            rd_shift_q <= rd_word;
         end else if (sck_fall && rd_act_q) begin
            sdo_q <= rd_shift_q[15];
            rd_shift_q <= {rd_shift_q[14:0], 1'b0};
         end
      end
   end

   // Reserved bits are stored as written so readback matches the map
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         regs_q <= RST_WORDS;
      end else if (wr_stb) begin
         regs_q[addr_idx(wr_addr)] <= wr_data;
      end
   end

   assign spi_sdo_out = sdo_q;
   assign spi_sdo_oe_out = rd_act_q & cs_act;
   assign ref_doubler_enable_out = regs_q[0][srp_pkg::SRP_DOUBLER_BIT];
   assign input_path_multiplier_out = regs_q[1][srp_pkg::SRP_INPUT_PATH_MULTIPLIER_MSB:srp_pkg::SRP_INPUT_PATH_MULTIPLIER_LSB];
   assign post_input_path_multiplier_divider_out = regs_q[2][srp_pkg::SRP_POST_MSB:srp_pkg::SRP_POST_LSB];
   assign pre_input_path_multiplier_divider_out = regs_q[3][srp_pkg::SRP_PRE_MSB:srp_pkg::SRP_PRE_LSB];
   assign pump_enable_out = regs_q[4][srp_pkg::SRP_PUMP_BIT];
   assign detector_mode_sel_out = regs_q[4][srp_pkg::SRP_MODE_MSB:srp_pkg::SRP_MODE_LSB];
   // Codes 1 and 2 are undefined; only 3 selects the single detector
   // Decoded at the write so the output comes straight from a flop
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         single_q <= (srp_pkg::SRP_RST_PUMP_DET[1:0] == srp_pkg::SRP_MODE_SINGLE);
      end else if (wr_stb && (wr_addr == srp_pkg::SRP_OFS_PUMP_DET)) begin
         single_q <= (wr_data[1:0] == srp_pkg::SRP_MODE_SINGLE);
      end
   end

   assign single_detector_out = single_q;

   logic [15:0] wr_data_h;
   logic [6:0] wr_addr_h;
   assign wr_data_h = wr_data;
   assign wr_addr_h = wr_addr;

   post_reset_a: assert property (@(posedge clk_in) $rose(rst_n_in) |-> post_input_path_multiplier_divider_out == 8'h01)
      else $error("post divider reset value wrong");
   pre_reset_a: assert property (@(posedge clk_in) $rose(rst_n_in) |-> pre_input_path_multiplier_divider_out == 12'h001)
      else $error("pre divider reset value wrong");
   pump_reset_a: assert property (@(posedge clk_in) $rose(rst_n_in) |-> pump_enable_out && !single_detector_out)
      else $error("pump not enabled or single mode after reset");
   mode_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (wr_stb && wr_addr_h == srp_pkg::SRP_OFS_PUMP_DET) |=>
      (single_detector_out == ($past(wr_data_h[1:0]) == srp_pkg::SRP_MODE_SINGLE)))
      else $error("detector mode not taken from write");
   pump_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (wr_stb && wr_addr_h == srp_pkg::SRP_OFS_PUMP_DET) |=> pump_enable_out == $past(wr_data_h[14]))
      else $error("pump enable not taken from write");
   input_path_multiplier_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (wr_stb && wr_addr_h == srp_pkg::SRP_OFS_INPUT_PATH_MULTIPLIER) |=> input_path_multiplier_out == $past(wr_data_h[11:7]))
      else $error("multiplier field not taken from write");
   doubler_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (wr_stb && wr_addr_h == srp_pkg::SRP_OFS_DOUBLER) |=> ref_doubler_enable_out == $past(wr_data_h[11]))
      else $error("doubler enable not taken from write");
   fields_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !wr_stb |=> $stable(post_input_path_multiplier_divider_out) && $stable(pre_input_path_multiplier_divider_out) && $stable(pump_enable_out))
      else $error("field changed without a write");
   mode_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !wr_stb |=> $stable(detector_mode_sel_out) && $stable(single_detector_out) &&
      $stable(ref_doubler_enable_out) && $stable(input_path_multiplier_out))
      else $error("mode or path field changed without a write");
   post_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (wr_stb && wr_addr_h == srp_pkg::SRP_OFS_POST_DIV) |=> post_input_path_multiplier_divider_out == $past(wr_data_h[11:4]))
      else $error("post divider not taken from write");
   pre_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (wr_stb && wr_addr_h == srp_pkg::SRP_OFS_PRE_DIV) |=> pre_input_path_multiplier_divider_out == $past(wr_data_h[11:0]))
      else $error("pre divider not taken from write");

   write_frame_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) wr_stb);
   read_frame_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) addr_rise && rd_req);
   single_mode_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(single_detector_out));
   pump_off_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) $fell(pump_enable_out));
   cut_frame_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      (state_q == srp_pkg::SRP_SHIFT) && !cs_act);
endmodule
